// >>> hw/status_reporting.sv
// Status registers, enable masks, serial-poll summary and panel control state.
`timescale 1ns/100ps

// Notes on behaviour
// - Poll bit 2 is high when any enabled fault flag is set.
// - Poll bit 3 is high when any enabled measurement flag is set.
// - Poll bit 4 follows the output-buffer-not-empty input exactly.
// - Poll bit 5 is high when any enabled standard event is set.
// - Poll bit 6 shows a raised service request; bits 0, 1, 7 read zero.
// - Event bits: done 0, rx overrun 1, tx overrun 3, power-up 7; bit 2 zero.
// - Event bit 4 flags a command that cannot run or a bad argument.
// - Event bit 5 flags an illegal command code.
// - Event bit 6 flags any front panel action.
// - Measurement bits 0, 1 and 8 to 11 flag output overloads; bit 2 zero.
// - Measurement bit 3 flags loss of reference lock.
// - Measurement bit 4 flags input range overload.
// - Measurement bits 5 and 6 flag notch frequency range and notch overload.
// - Measurement bit 7 flags data storage triggered.
// - Measurement bits 12, 13, 14 flag capture done, sweep start, sweep end.
// - Fault bits: clock 0, battery 1, network 4; bits 2 and 3 zero.
// - Fault bit 5 flags an aborted fast transfer.
// - Fault bits 6 and 7 flag host link and memory stick faults.
// - Clear-all zeroes status registers; the four masks are writable and readable.
// - A host-settable bit decides whether masks clear at a warm reset; a cold start always clears them.
// - Panel state 0 local, 1 remote, 2 lockout, set by the host.
// - A query returns the live overload conditions, not the latched bits.
module status_reporting (
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    cold_start,
    input  wire logic                    cmd_valid,
    input  wire status_pkg::cmd_type     cmd,
    output logic                         resp_valid,
    output logic [15:0]                  resp_data,
    input  wire status_pkg::event_in_type event_in,
    input  wire status_pkg::meas_in_type meas_in,
    input  wire status_pkg::fault_in_type fault_in,
    input  wire logic                    reply_waiting,
    output logic                         service_request,
    output status_pkg::panel_type        panel_control_state,
    output logic                         bus_override_remote
);

    logic [7:0]            event_q;
    logic [7:0]            event_d;
    logic [15:0]           meas_q;
    logic [15:0]           meas_d;
    logic [7:0]            fault_q;
    logic [7:0]            fault_d;
    logic [7:0]            event_en_q;
    logic [7:0]            poll_en_q;
    logic [7:0]            fault_en_q;
    logic [15:0]           meas_en_q;
    logic                  psc_q;
    status_pkg::panel_type panel_q;
    logic                  override_q;
    logic                  resp_valid_q;
    logic [15:0]           resp_data_q;

    wire logic [4:0]  code = cmd.code;
    wire logic [15:0] arg  = cmd.arg;

    // Everything the decode reads is an argument, so each wire re-evaluates on any change.
    function automatic logic is_cmd(input logic valid, input logic [4:0] got,
                                    input logic [4:0] want);
        return valid && (got == want);
    endfunction

    wire logic clear_all   = is_cmd(cmd_valid, code, status_pkg::CMD_CLEAR_ALL);
    wire logic rd_event    = is_cmd(cmd_valid, code, status_pkg::CMD_GET_EVENT);
    wire logic rd_meas     = is_cmd(cmd_valid, code, status_pkg::CMD_GET_MEAS);
    wire logic rd_fault    = is_cmd(cmd_valid, code, status_pkg::CMD_GET_FAULT);
    wire logic rd_poll     = is_cmd(cmd_valid, code, status_pkg::CMD_GET_POLL);
    wire logic rd_live     = is_cmd(cmd_valid, code, status_pkg::CMD_GET_LIVE);
    wire logic wr_event_en = is_cmd(cmd_valid, code, status_pkg::CMD_SET_EVENT_EN);
    wire logic wr_poll_en  = is_cmd(cmd_valid, code, status_pkg::CMD_SET_POLL_EN);
    wire logic wr_fault_en = is_cmd(cmd_valid, code, status_pkg::CMD_SET_FAULT_EN);
    wire logic wr_meas_en  = is_cmd(cmd_valid, code, status_pkg::CMD_SET_MEAS_EN);
    wire logic wr_psc      = is_cmd(cmd_valid, code, status_pkg::CMD_SET_PSC);
    wire logic wr_panel    = is_cmd(cmd_valid, code, status_pkg::CMD_SET_PANEL);
    wire logic wr_override = is_cmd(cmd_valid, code, status_pkg::CMD_SET_OVERRIDE);

    wire logic code_known = (code <= status_pkg::CMD_GET_OVERRIDE);
    wire logic is_query   = cmd_valid && code_known && !clear_all
                            && !wr_event_en && !wr_poll_en && !wr_fault_en
                            && !wr_meas_en && !wr_psc && !wr_panel && !wr_override;
    wire logic illegal_cmd = cmd_valid && !code_known;
    // A panel state above lockout, or any byte-wide setting with high bits, cannot run.
    wire logic bad_arg = (wr_panel && (arg > 16'(status_pkg::PANEL_LOCKOUT)))
                         || ((wr_event_en || wr_poll_en || wr_fault_en) && (arg[15:8] != 8'h00))
                         || ((wr_psc || wr_override) && (arg[15:1] != 15'h0000));

    wire logic fault_sum = |(fault_q & fault_en_q);
    wire logic meas_sum  = |(meas_q & meas_en_q);
    wire logic event_sum = |(event_q & event_en_q);
    wire logic [7:0] poll_base = {2'b00, event_sum, reply_waiting,
                                  meas_sum, fault_sum, 2'b00};
    // Service request is raised by any summary bit its mask enables.
    wire logic srq = |(poll_base & poll_en_q & status_pkg::POLL_USED_MASK);
    wire logic [7:0] poll_byte = poll_base | {1'b0, srq, 6'h00};

    wire logic [7:0] event_set = (8'(event_in) & status_pkg::EVENT_USED_MASK)
                                 | {2'b00, illegal_cmd, bad_arg, 4'h0};
    wire logic [15:0] meas_set = 16'(meas_in) & status_pkg::MEAS_USED_MASK;
    wire logic [7:0] fault_set = 8'(fault_in) & status_pkg::FAULT_USED_MASK;

    // A set in the clearing cycle survives the clear.
    assign event_d = ((rd_event || clear_all) ? 8'h00 : event_q) | event_set;
    assign meas_d  = ((rd_meas || clear_all) ? 16'h0000 : meas_q) | meas_set;
    assign fault_d = ((rd_fault || clear_all) ? 8'h00 : fault_q) | fault_set;

    logic [15:0] resp_sel;
    always_comb begin
        resp_sel = 16'h0000;
        case (code)
            status_pkg::CMD_GET_EVENT_EN: resp_sel = {8'h00, event_en_q};
            status_pkg::CMD_GET_EVENT:    resp_sel = {8'h00, event_q};
            status_pkg::CMD_GET_POLL_EN:  resp_sel = {8'h00, poll_en_q};
            status_pkg::CMD_GET_POLL:     resp_sel = {8'h00, poll_byte};
            status_pkg::CMD_GET_PSC:      resp_sel = {15'h0000, psc_q};
            status_pkg::CMD_GET_FAULT_EN: resp_sel = {8'h00, fault_en_q};
            status_pkg::CMD_GET_FAULT:    resp_sel = {8'h00, fault_q};
            status_pkg::CMD_GET_MEAS_EN:  resp_sel = meas_en_q;
            status_pkg::CMD_GET_MEAS:     resp_sel = meas_q;
            status_pkg::CMD_GET_LIVE:     resp_sel = 16'(meas_in) & status_pkg::LIVE_OVERLOAD_MASK;
            status_pkg::CMD_GET_PANEL:    resp_sel = {14'h0000, panel_q};
            status_pkg::CMD_GET_OVERRIDE: resp_sel = {15'h0000, override_q};
            default:                      resp_sel = 16'h0000;
        endcase
    end

    // Status flags; power-up sets the power-up event.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            event_q <= status_pkg::EVENT_RESET;
            meas_q  <= status_pkg::MEAS_RESET;
            fault_q <= status_pkg::FAULT_RESET;
        end else begin
            event_q <= event_d;
            meas_q  <= meas_d;
            fault_q <= fault_d;
        end
    end

    // Masks survive a reset unless power-on clear is selected or this is a cold start.
    always_ff @(posedge ref_clk) begin
        if (reset && (psc_q || cold_start)) begin
            event_en_q <= status_pkg::ENABLE_RESET[7:0];
            poll_en_q  <= status_pkg::ENABLE_RESET[7:0];
            fault_en_q <= status_pkg::ENABLE_RESET[7:0];
            meas_en_q  <= status_pkg::ENABLE_RESET;
        end else if (!reset) begin
            if (wr_event_en && !bad_arg) event_en_q <= arg[7:0];
            if (wr_poll_en && !bad_arg)  poll_en_q  <= arg[7:0];
            if (wr_fault_en && !bad_arg) fault_en_q <= arg[7:0];
            if (wr_meas_en)              meas_en_q  <= arg;
        end
    end

    // The power-on clear bit itself is kept across warm resets.
    always_ff @(posedge ref_clk) begin
        if (reset && cold_start) begin
            psc_q <= status_pkg::PSC_RESET;
        end else if (!reset && wr_psc && !bad_arg) begin
            psc_q <= arg[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            panel_q    <= status_pkg::PANEL_RESET;
            override_q <= status_pkg::OVERRIDE_RESET;
        end else begin
            if (wr_panel && !bad_arg) panel_q    <= status_pkg::panel_type'(arg[1:0]);
            if (wr_override && !bad_arg) override_q <= arg[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            resp_valid_q <= 1'b0;
            resp_data_q  <= 16'h0000;
        end else begin
            resp_valid_q <= is_query;
            if (is_query) resp_data_q <= resp_sel;
        end
    end

    assign resp_valid          = resp_valid_q;
    assign resp_data           = resp_data_q;
    assign service_request     = srq;
    assign panel_control_state = panel_q;
    assign bus_override_remote = override_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence poll_query;
        rd_poll;
    endsequence

    sequence quiet_inputs;
        (event_set == 8'h00) && (meas_set == 16'h0000) && (fault_set == 8'h00);
    endsequence

    a_fault_summary_set: assert property (
        ((fault_set & fault_en_q) != 8'h00) && !wr_fault_en |=> poll_byte[2])
        else $error("Enabled fault did not raise poll bit 2.");

    a_meas_summary_set: assert property (
        ((meas_set & meas_en_q) != 16'h0000) && !wr_meas_en |=> poll_byte[3])
        else $error("Enabled measurement flag did not raise poll bit 3.");

    a_reply_bit_answer: assert property (
        poll_query |=> resp_valid && (resp_data[4] == $past(reply_waiting)))
        else $error("Poll answer bit 4 did not follow the reply input.");

    a_event_summary_set: assert property (
        event_in.operation_done && event_en_q[0] && !wr_event_en |=> poll_byte[5])
        else $error("Enabled operation done did not raise poll bit 5.");

    a_poll_unused_zero: assert property (
        poll_query |=> (resp_data[15:8] == 8'h00) && !resp_data[7] && (resp_data[1:0] == 2'b00))
        else $error("Unused poll bits read nonzero.");

    a_srq_follows_enable: assert property (
        event_sum && poll_en_q[5] |-> service_request && poll_byte[6])
        else $error("Enabled event summary did not raise service request.");

    a_event_bits_latch: assert property (
        event_in.rx_queue_overrun |=> event_q[1] && !event_q[2])
        else $error("Receive overrun not latched in event bit 1.");

    a_illegal_cmd_flag: assert property (
        cmd_valid && (code > status_pkg::CMD_GET_OVERRIDE) |=> event_q[5] && !resp_valid)
        else $error("Illegal command did not set event bit 5.");

    a_bad_panel_arg: assert property (
        wr_panel && (arg[1:0] == 2'h3) |=> event_q[4] && (panel_q == $past(panel_q)))
        else $error("Bad panel value not refused with event bit 4.");

    a_fault_hold_read: assert property (
        fault_q[5] && !rd_fault && !clear_all |=> fault_q[5])
        else $error("Fault flag dropped without a read.");

    a_clear_all_zero: assert property (
        clear_all ##0 quiet_inputs |=> (event_q == 8'h00) && (meas_q == 16'h0000)
                                       && (fault_q == 8'h00))
        else $error("Clear-all left a status flag set.");

    a_panel_state_set: assert property (
        wr_panel && (arg == 16'h0002) |=> panel_control_state == status_pkg::PANEL_LOCKOUT
                                         ##1 panel_control_state == status_pkg::PANEL_LOCKOUT
                                             || $past(wr_panel))
        else $error("Panel state did not take lockout.");

    a_live_query_value: assert property (
        rd_live |=> resp_valid
            && (resp_data == ($past(16'(meas_in)) & status_pkg::LIVE_OVERLOAD_MASK)))
        else $error("Live overload answer wrong.");

    a_done_latch: assert property (
        event_in.operation_done |=> event_q[0])
        else $error("Event bit 0 missed.");

    a_tx_overrun_latch: assert property (
        event_in.tx_queue_overrun |=> event_q[3])
        else $error("Event bit 3 missed.");

    a_power_up_latch: assert property (
        event_in.power_up_event |=> event_q[7])
        else $error("Event bit 7 missed.");

    a_event_spare_zero: assert property (
        !event_q[2])
        else $error("Event bit 2 set.");

    a_run_fault_latch: assert property (
        event_in.run_fault |=> event_q[4])
        else $error("Event bit 4 missed.");

    a_bad_mask_arg: assert property (
        wr_event_en && (arg[15:8] != 8'h00) |=> event_q[4] && $stable(event_en_q))
        else $error("Bad event mask taken.");

    a_touch_latch: assert property (
        event_in.panel_touched |=> event_q[6])
        else $error("Event bit 6 missed.");

    a_out1_ovl_latch: assert property (
        meas_in.analog_out1_overload |=> meas_q[0])
        else $error("Meas bit 0 missed.");

    a_meas_spare_zero: assert property (
        !meas_q[2] && !meas_q[15])
        else $error("Unused meas bit set.");

    a_data1_ovl_latch: assert property (
        meas_in.data_ch1_overload |=> meas_q[8])
        else $error("Meas bit 8 missed.");

    a_unlock_latch: assert property (
        meas_in.ref_lock_lost |=> meas_q[3])
        else $error("Meas bit 3 missed.");

    a_range_latch: assert property (
        meas_in.range_overload |=> meas_q[4])
        else $error("Meas bit 4 missed.");

    a_notch_freq_latch: assert property (
        meas_in.notch_freq_out_of_bounds |=> meas_q[5])
        else $error("Meas bit 5 missed.");

    a_notch_ovl_latch: assert property (
        meas_in.notch_overload |=> meas_q[6])
        else $error("Meas bit 6 missed.");

    a_storage_latch: assert property (
        meas_in.storage_armed_event |=> meas_q[7])
        else $error("Meas bit 7 missed.");

    a_capture_latch: assert property (
        meas_in.screenshot_done |=> meas_q[12])
        else $error("Meas bit 12 missed.");

    a_sweep_start_latch: assert property (
        meas_in.sweep_begun |=> meas_q[13])
        else $error("Meas bit 13 missed.");

    a_sweep_end_latch: assert property (
        meas_in.sweep_finished |=> meas_q[14])
        else $error("Meas bit 14 missed.");

    a_clock_fault_latch: assert property (
        fault_in.ext_clock_fault |=> fault_q[0])
        else $error("Fault bit 0 missed.");

    a_battery_latch: assert property (
        fault_in.battery_backup_fault |=> fault_q[1])
        else $error("Fault bit 1 missed.");

    a_fault_spare_zero: assert property (
        fault_q[3:2] == 2'b00)
        else $error("Unused fault bit set.");

    a_network_latch: assert property (
        fault_in.network_protocol_fault |=> fault_q[4])
        else $error("Fault bit 4 missed.");

    a_abort_latch: assert property (
        fault_in.fast_transfer_abort |=> fault_q[5])
        else $error("Fault bit 5 missed.");

    a_link_fault_latch: assert property (
        fault_in.host_link_device_fault |=> fault_q[6])
        else $error("Fault bit 6 missed.");

    a_stick_fault_latch: assert property (
        fault_in.memory_stick_fault |=> fault_q[7])
        else $error("Fault bit 7 missed.");

    a_psc_write: assert property (
        wr_psc && !bad_arg |=> psc_q == $past(arg[0]))
        else $error("Clear bit not written.");

    a_poll_mask_write: assert property (
        wr_poll_en && !bad_arg |=> poll_en_q == $past(arg[7:0]))
        else $error("Poll mask not written.");

    a_meas_mask_write: assert property (
        wr_meas_en |=> meas_en_q == $past(arg))
        else $error("Meas mask not written.");

    a_reply_bit_live: assert property (
        poll_byte[4] == reply_waiting)
        else $error("Poll bit 4 off.");

endmodule

// >>> hw/status_pkg.sv
// Shared constants and types for the instrument status reporting block.
package status_pkg;

    // Serial-poll byte bit positions.
    localparam int unsigned FAULT_SUM_BIT = 2;
    localparam int unsigned MEAS_SUM_BIT  = 3;
    localparam int unsigned REPLY_BIT     = 4;
    localparam int unsigned EVENT_SUM_BIT = 5;
    localparam int unsigned SRQ_BIT       = 6;

    // Standard event bit positions.
    localparam int unsigned RUN_FAULT_BIT   = 4;
    localparam int unsigned BAD_COMMAND_BIT = 5;

    // Implemented bits of each status register; unused bits read as zero.
    localparam logic [7:0]  EVENT_USED_MASK = 8'hfb;
    localparam logic [15:0] MEAS_USED_MASK  = 16'h7ffb;
    localparam logic [7:0]  FAULT_USED_MASK = 8'hf3;
    localparam logic [7:0]  POLL_USED_MASK  = 8'h7c;
    // Measurement bits that are live overload conditions.
    localparam logic [15:0] LIVE_OVERLOAD_MASK = 16'h0f53;

    // Reset values.
    localparam logic [7:0]  EVENT_RESET  = 8'h80;
    localparam logic [15:0] MEAS_RESET   = 16'h0000;
    localparam logic [7:0]  FAULT_RESET  = 8'h00;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic        PSC_RESET    = 1'b1;
    localparam logic        OVERRIDE_RESET = 1'b0;

    // Host command codes on the command port.
    localparam logic [4:0] CMD_CLEAR_ALL     = 5'h00;
    localparam logic [4:0] CMD_SET_EVENT_EN  = 5'h01;
    localparam logic [4:0] CMD_GET_EVENT_EN  = 5'h02;
    localparam logic [4:0] CMD_GET_EVENT     = 5'h03;
    localparam logic [4:0] CMD_SET_POLL_EN   = 5'h04;
    localparam logic [4:0] CMD_GET_POLL_EN   = 5'h05;
    localparam logic [4:0] CMD_GET_POLL      = 5'h06;
    localparam logic [4:0] CMD_SET_PSC       = 5'h07;
    localparam logic [4:0] CMD_GET_PSC       = 5'h08;
    localparam logic [4:0] CMD_SET_FAULT_EN  = 5'h09;
    localparam logic [4:0] CMD_GET_FAULT_EN  = 5'h0a;
    localparam logic [4:0] CMD_GET_FAULT     = 5'h0b;
    localparam logic [4:0] CMD_SET_MEAS_EN   = 5'h0c;
    localparam logic [4:0] CMD_GET_MEAS_EN   = 5'h0d;
    localparam logic [4:0] CMD_GET_MEAS      = 5'h0e;
    localparam logic [4:0] CMD_GET_LIVE      = 5'h0f;
    localparam logic [4:0] CMD_SET_PANEL     = 5'h10;
    localparam logic [4:0] CMD_GET_PANEL     = 5'h11;
    localparam logic [4:0] CMD_SET_OVERRIDE  = 5'h12;
    localparam logic [4:0] CMD_GET_OVERRIDE  = 5'h13;

    typedef enum logic [1:0] {
        PANEL_LOCAL   = 2'h0,
        PANEL_REMOTE  = 2'h1,
        PANEL_LOCKOUT = 2'h2
    } panel_type;

    localparam panel_type PANEL_RESET = PANEL_LOCAL;

    typedef struct packed {
        logic [4:0]  code;
        logic [15:0] arg;
    } cmd_type;

    // One-cycle event pulses, packed in standard event bit order.
    typedef struct packed {
        logic power_up_event;
        logic panel_touched;
        logic bad_command;
        logic run_fault;
        logic tx_queue_overrun;
        logic spare2;
        logic rx_queue_overrun;
        logic operation_done;
    } event_in_type;

    // Measurement conditions, packed in measurement word bit order.
    typedef struct packed {
        logic spare15;
        logic sweep_finished;
        logic sweep_begun;
        logic screenshot_done;
        logic data_ch4_overload;
        logic data_ch3_overload;
        logic data_ch2_overload;
        logic data_ch1_overload;
        logic storage_armed_event;
        logic notch_overload;
        logic notch_freq_out_of_bounds;
        logic range_overload;
        logic ref_lock_lost;
        logic spare2;
        logic analog_out2_overload;
        logic analog_out1_overload;
    } meas_in_type;

    // Fault conditions, packed in fault flag bit order.
    typedef struct packed {
        logic memory_stick_fault;
        logic host_link_device_fault;
        logic fast_transfer_abort;
        logic network_protocol_fault;
        logic spare3;
        logic spare2;
        logic battery_backup_fault;
        logic ext_clock_fault;
    } fault_in_type;

endpackage

// >>> sim/host_model.sv
// Behavioural remote host that issues commands and collects the answers.
`timescale 1ns/100ps
module host_model (
    input  wire logic           ref_clk,
    output logic                cmd_valid,
    output status_pkg::cmd_type cmd,
    input  wire logic           resp_valid,
    input  wire logic [15:0]    resp_data
);
    logic        got_valid;
    logic [15:0] got_data;

    initial begin
        cmd_valid = 1'b0;
        cmd = 21'h000000;
    end

    // One command per call; a released bus shows the inverse of its last value.
    task automatic send(input logic [4:0] code, input logic [15:0] arg);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd <= {code, arg};
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd <= ~cmd;
        #1;
        got_valid = resp_valid;
        got_data = resp_data;
    endtask
endmodule

// >>> sim/testbench.sv
// Self-checking bench comparing the status block with a behavioural model.
`timescale 1ns/100ps
module testbench;
    logic                     ref_clk;
    logic                     reset;
    logic                     cold_start;
    logic                     cmd_valid;
    status_pkg::cmd_type      cmd;
    logic                     resp_valid;
    logic [15:0]              resp_data;
    status_pkg::event_in_type event_in;
    status_pkg::meas_in_type  meas_in;
    status_pkg::fault_in_type fault_in;
    logic                     reply_waiting;
    logic                     service_request;
    status_pkg::panel_type    panel_control_state;
    logic                     bus_override_remote;
    int                       errors;
    int                       checked;
    int                       m_ev, m_ms, m_ft, m_een, m_pen, m_fen, m_men, m_psc, m_rw;
    int                       k;
    int                       r;

    status_reporting uut (
        .ref_clk(ref_clk), .reset(reset), .cold_start(cold_start), .cmd_valid(cmd_valid),
        .cmd(cmd), .resp_valid(resp_valid), .resp_data(resp_data), .event_in(event_in),
        .meas_in(meas_in), .fault_in(fault_in), .reply_waiting(reply_waiting),
        .service_request(service_request), .panel_control_state(panel_control_state),
        .bus_override_remote(bus_override_remote)
    );

    host_model u_host (
        .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd),
        .resp_valid(resp_valid), .resp_data(resp_data)
    );

    task automatic print_verdict();
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_resp(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_srq(input logic got, input logic exp);
        chk_resp({16'h0000, got}, {16'h0000, exp});
    endtask

    task automatic query(input logic [4:0] code, input int exp);
        u_host.send(code, 16'h0000);
        chk_resp({u_host.got_valid, u_host.got_data}, {1'b1, exp[15:0]});
        if (code == status_pkg::CMD_GET_EVENT) m_ev = 0;
        if (code == status_pkg::CMD_GET_MEAS) m_ms = 0;
        if (code == status_pkg::CMD_GET_FAULT) m_ft = 0;
    endtask

    // One-cycle condition pulses; the model latches only implemented bits.
    task automatic pulse(input int ev, input int ms, input int ft);
        @(posedge ref_clk);
        event_in <= ev[7:0];
        meas_in <= ms[15:0];
        fault_in <= ft[7:0];
        reply_waiting <= m_rw[0];
        m_ev = m_ev | (ev & status_pkg::EVENT_USED_MASK);
        m_ms = m_ms | (ms & status_pkg::MEAS_USED_MASK);
        m_ft = m_ft | (ft & status_pkg::FAULT_USED_MASK);
        @(posedge ref_clk);
        event_in <= 8'h00;
        meas_in <= 16'h0000;
        fault_in <= 8'h00;
    endtask

    task automatic do_reset(input logic cold);
        @(posedge ref_clk);
        reset <= 1'b1;
        cold_start <= cold;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        cold_start <= 1'b0;
        if (m_psc != 0 || cold) begin
            m_een = 0;
            m_pen = 0;
            m_fen = 0;
            m_men = 0;
        end
        if (cold) m_psc = 1;
        m_ev = status_pkg::EVENT_RESET;
        m_ms = 0;
        m_ft = 0;
    endtask

    function automatic int exp_poll();
        int p;
        p = m_rw << 4;
        if ((m_ft & m_fen) != 0) p = p | 32'h04;
        if ((m_ms & m_men) != 0) p = p | 32'h08;
        if ((m_ev & m_een) != 0) p = p | 32'h20;
        if ((p & m_pen) != 0) p = p | 32'h40;
        return p;
    endfunction

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (6000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end

    initial begin
        reset = 1'b1;
        cold_start = 1'b1;
        event_in = 8'h00;
        meas_in = 16'h0000;
        fault_in = 8'h00;
        reply_waiting = 1'b0;
        errors = 0;
        checked = 0;
        m_psc = 0;
        m_rw = 0;
        void'($urandom(95318));
        do_reset(1'b1);
        query(status_pkg::CMD_GET_EVENT, m_ev);
        query(status_pkg::CMD_GET_EVENT, 0);
        query(status_pkg::CMD_GET_PSC, 1);
        for (k = 0; k < 16; k++) begin
            pulse(1 << k, 1 << k, 1 << k);
            query(status_pkg::CMD_GET_EVENT, m_ev);
            query(status_pkg::CMD_GET_MEAS, m_ms);
            query(status_pkg::CMD_GET_FAULT, m_ft);
        end
        for (k = 0; k < 12; k++) begin
            m_een = $urandom & 32'hff;
            m_pen = $urandom & 32'h3c;
            m_fen = $urandom & 32'hff;
            m_men = $urandom & 32'hffff;
            m_rw = $urandom & 32'h1;
            u_host.send(status_pkg::CMD_SET_EVENT_EN, m_een[15:0]);
            u_host.send(status_pkg::CMD_SET_POLL_EN, m_pen[15:0]);
            u_host.send(status_pkg::CMD_SET_FAULT_EN, m_fen[15:0]);
            u_host.send(status_pkg::CMD_SET_MEAS_EN, m_men[15:0]);
            query(status_pkg::CMD_GET_MEAS_EN, m_men);
            query(status_pkg::CMD_GET_FAULT_EN, m_fen);
            query(status_pkg::CMD_GET_POLL_EN, m_pen);
            u_host.send(status_pkg::CMD_CLEAR_ALL, 16'h0000);
            m_ev = 0;
            m_ms = 0;
            m_ft = 0;
            pulse($urandom & $urandom, $urandom & $urandom, $urandom & $urandom);
            query(status_pkg::CMD_GET_POLL, exp_poll());
            chk_srq(service_request, exp_poll() >= 32'h40);
        end
        pulse(32'hff, 32'hffff, 32'hff);
        u_host.send(status_pkg::CMD_CLEAR_ALL, 16'h0000);
        query(status_pkg::CMD_GET_EVENT, 0);
        query(status_pkg::CMD_GET_MEAS, 0);
        query(status_pkg::CMD_GET_FAULT, 0);
        for (k = 32'h14; k < 32'h20; k++) begin
            u_host.send(k[4:0], 16'h0000);
            query(status_pkg::CMD_GET_EVENT, 32'h20);
        end
        u_host.send(status_pkg::CMD_SET_PANEL, 16'h0003);
        query(status_pkg::CMD_GET_EVENT, 32'h10);
        u_host.send(status_pkg::CMD_SET_EVENT_EN, 16'h0100);
        query(status_pkg::CMD_GET_EVENT, 32'h10);
        for (k = 2; k >= 0; k--) begin
            u_host.send(status_pkg::CMD_SET_PANEL, k[15:0]);
            query(status_pkg::CMD_GET_PANEL, k);
            chk_resp({15'h0000, panel_control_state}, k[16:0]);
        end
        u_host.send(status_pkg::CMD_SET_OVERRIDE, 16'h0001);
        query(status_pkg::CMD_GET_OVERRIDE, 1);
        chk_srq(bus_override_remote, 1'b1);
        u_host.send(status_pkg::CMD_SET_PSC, 16'h0000);
        m_psc = 0;
        query(status_pkg::CMD_GET_PSC, 0);
        do_reset(1'b0);
        query(status_pkg::CMD_GET_MEAS_EN, m_men);
        u_host.send(status_pkg::CMD_SET_PSC, 16'h0001);
        m_psc = 1;
        do_reset(1'b0);
        query(status_pkg::CMD_GET_MEAS_EN, 0);
        query(status_pkg::CMD_GET_EVENT, m_ev);
        r = $urandom & 32'h7ffb;
        @(posedge ref_clk);
        meas_in <= r[15:0];
        query(status_pkg::CMD_GET_LIVE, r & status_pkg::LIVE_OVERLOAD_MASK);
        @(posedge ref_clk);
        meas_in <= 16'h0000;
        query(status_pkg::CMD_GET_LIVE, 0);
        query(status_pkg::CMD_GET_MEAS, r);
        print_verdict();
    end
endmodule
